// [core/flash_host_pkg.sv]
// Shared constants and types for the parallel boot-block flash host controller
`default_nettype none
package flash_host_pkg;
   // ==========================================
   // Timing
   localparam int CLK_MHZ = 200;
   localparam int ACCESS_NS = 80;
   localparam int SETUP_NS = 10;
   localparam int STROBE_NS = 50;
   localparam int RECOVER_NS = 20;
   localparam int SYNC_CYC = 2;
   localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] SETUP_CNT = 8'(SETUP_CYC - 1);
   localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC - 1);
   localparam logic [7:0] READ_CNT = 8'(ACCESS_CYC + SYNC_CYC - 1);
   localparam logic [7:0] RECOVER_CNT = 8'(RECOVER_CYC - 1);
   // ==========================================
   // Register map
   localparam logic [7:0] OFF_OP = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_CFG = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_RDATA = 8'h14;
   localparam int OP_KIND_LSB = 0;
   localparam int OP_CODE_LSB = 8;
   localparam int CFG_WORD = 0;
   localparam int CFG_WP = 1;
   localparam int CFG_UNLOCK = 2;
   localparam int CFG_IDENT = 3;
   localparam int CFG_VPP = 4;
   localparam int CFG_SLEEP = 5;
   localparam logic [5:0] CFG_RESET = 6'h01;
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_MODE_LSB = 4;
   // ==========================================
   // Device commands and map
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [17:0] BOOT_BOTTOM_END = 18'h02000;
   localparam logic [17:0] BOOT_TOP_START = 18'h3e000;
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_CMD = 2'h1,
      OP_PROG = 2'h2,
      OP_ERASE = 2'h3
   } op_t;
   typedef enum logic [1:0] {
      MODE_ARRAY = 2'h0,
      MODE_STATUS = 2'h1,
      MODE_IDENT = 2'h2
   } mode_t;
endpackage
`default_nettype wire

// [core/pin_sync.sv]
// Two-stage synchroniser for pin inputs
`default_nettype none
module pin_sync #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] stage_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_reg <= '0;
         syncOut <= '0;
      end else begin
         stage_reg <= pinIn;
         syncOut <= stage_reg;
      end
   end
endmodule
`default_nettype wire

// [core/apb_regs.sv]
// APB register file of the flash host controller
`default_nettype none
module apb_regs (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic startOp,
   output var flash_host_pkg::op_t opKind,
   output logic [7:0] opCode,
   output logic [18:0] opAddr,
   output logic [15:0] opWdata,
   output logic [5:0] cfg,
   output logic refuseClr,
   input wire logic busy,
   input wire logic refused,
   input wire flash_host_pkg::mode_t mode,
   input wire logic [15:0] rdData
);
   import flash_host_pkg::*;
   // ==========================================
   // Decode
   wire access = psel && penable;
   wire hitOp = paddr == OFF_OP;
   wire hitAddr = paddr == OFF_ADDR;
   wire hitWdata = paddr == OFF_WDATA;
   wire hitCfg = paddr == OFF_CFG;
   wire hitStatus = paddr == OFF_STATUS;
   wire hitRdata = paddr == OFF_RDATA;
   wire mapped = hitOp | hitAddr | hitWdata | hitCfg | hitStatus | hitRdata;
   wire opBusy = hitOp && pwrite && busy;
   wire wr = access && pwrite && mapped && !opBusy;
   wire [31:0] statusWord = {26'h0, mode, 2'h0, refused, busy};
   assign pready = 1'b1;
   assign pslverr = access && (!mapped || opBusy);
   assign prdata = !(psel && !pwrite) ? 32'h0 :
                   hitOp ? {16'h0, opCode, 6'h0, opKind} :
                   hitAddr ? {13'h0, opAddr} :
                   hitWdata ? {16'h0, opWdata} :
                   hitCfg ? {26'h0, cfg} :
                   hitStatus ? statusWord :
                   hitRdata ? {16'h0, rdData} : 32'h0;
   // ==========================================
   // Registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         opKind <= OP_READ;
         opCode <= 8'h00;
         opAddr <= 19'h00000;
         opWdata <= 16'h0000;
         cfg <= CFG_RESET;
      end else if (wr) begin
         if (hitOp) begin
            opKind <= op_t'(pwdata[OP_KIND_LSB +: 2]);
            opCode <= pwdata[OP_CODE_LSB +: 8];
         end
         if (hitAddr) opAddr <= pwdata[18:0];
         if (hitWdata) opWdata <= pwdata[15:0];
         if (hitCfg) cfg <= pwdata[5:0];
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         startOp <= 1'b0;
         refuseClr <= 1'b0;
      end else begin
         startOp <= wr && hitOp;
         refuseClr <= wr && hitStatus && pwdata[ST_REFUSED];
      end
   end
endmodule
`default_nettype wire

// [core/flash_host.sv]
// Host controller driving a parallel boot-block flash through its strobes
`default_nettype none
module flash_host #(
   parameter bit BOOT_TOP = 1'b0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chipEnableN,
   output logic outEnableN,
   output logic writeEnableN,
   output logic byteSelN,
   output logic [17:0] addrPins,
   input wire logic [15:0] dqIn,
   output logic [15:0] dqOut,
   output logic [15:0] dqOe,
   output logic wpPin,
   output logic resetPowerdownN,
   output logic unlockHighVoltage,
   output logic programSupplyHigh,
   output logic identHighVoltage
);
   import flash_host_pkg::*;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SETUP = 4'b0010,
      S_STROBE = 4'b0100,
      S_RECOVER = 4'b1000
   } state_t;
   // ==========================================
   // Register file and pin synchroniser
   logic startOp;
   logic refuseClr;
   op_t opKind;
   logic [7:0] opCode;
   logic [18:0] opAddr;
   logic [15:0] opWdata;
   logic [5:0] cfg;
   logic [15:0] syncDq;
   state_t state_reg, state_next;
   logic [7:0] count_reg, count_next;
   logic phase_reg, phase_next;
   op_t kind_reg;
   logic [7:0] code_reg;
   logic [15:0] wdata_reg;
   logic wordMode_reg;
   logic [15:0] rdata_reg;
   logic [7:0] lastCode_reg;
   mode_t mode_reg;
   logic refused_reg;
   logic [2:0] hold_reg;
   logic addrLow_reg;
   wire busy = state_reg != S_IDLE;
   apb_regs regs (
      .clk(clk),
      .reset_n(reset_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .startOp(startOp),
      .opKind(opKind),
      .opCode(opCode),
      .opAddr(opAddr),
      .opWdata(opWdata),
      .cfg(cfg),
      .refuseClr(refuseClr),
      .busy(busy),
      .refused(refused_reg),
      .mode(mode_reg),
      .rdData(rdata_reg)
   );
   pin_sync #(.W(16)) dqSync (
      .clk(clk),
      .reset_n(reset_n),
      .pinIn(dqIn),
      .syncOut(syncDq)
   );
   // ==========================================
   // Decode
   wire accept = startOp && !busy;
   wire wordCfg = cfg[CFG_WORD];
   wire [17:0] startWord = wordCfg ? opAddr[17:0] : opAddr[18:1];
   wire bootHit = BOOT_TOP ? (startWord >= BOOT_TOP_START) : (startWord < BOOT_BOTTOM_END);
   wire changesArray = opKind == OP_PROG || opKind == OP_ERASE;
   wire unlocked = cfg[CFG_WP] || cfg[CFG_UNLOCK];
   wire refuse = accept && changesArray && bootHit && !unlocked;
   wire isRead = kind_reg == OP_READ;
   wire twoCycle = kind_reg == OP_PROG || kind_reg == OP_ERASE;
   wire dataPhase = phase_reg && kind_reg == OP_PROG;
   wire [7:0] setupCode = kind_reg == OP_CMD ? code_reg :
                          kind_reg == OP_PROG ? CMD_WRITE_SETUP : CMD_ERASE_SETUP;
   wire [7:0] curCode = !phase_reg ? setupCode : dataPhase ? wdata_reg[7:0] : CMD_ERASE_GO;
   wire [15:0] driveWord = dataPhase ? wdata_reg : {8'h00, curCode};
   wire strobeEnd = state_reg == S_STROBE && count_reg == 8'h00;
   wire opEnd = state_reg == S_RECOVER && count_reg == 8'h00 && !(twoCycle && !phase_reg);
   wire driveNext = state_next != S_IDLE && !isRead;
   wire wideNext = wordMode_reg && dataPhase;
   wire holdPins = busy || accept;
   // ==========================================
   // Sequencer
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      phase_next = phase_reg;
      unique case (state_reg)
         S_IDLE: begin
            if (accept && !refuse) begin
               state_next = S_SETUP;
               count_next = SETUP_CNT;
               phase_next = 1'b0;
            end
         end
         S_SETUP: begin
            if (count_reg == 8'h00) begin
               state_next = S_STROBE;
               count_next = isRead ? READ_CNT : STROBE_CNT;
            end else begin
               count_next = count_reg - 8'h01;
            end
         end
         S_STROBE: begin
            if (count_reg == 8'h00) begin
               state_next = S_RECOVER;
               count_next = RECOVER_CNT;
            end else begin
               count_next = count_reg - 8'h01;
            end
         end
         S_RECOVER: begin
            if (count_reg != 8'h00) begin
               count_next = count_reg - 8'h01;
            end else if (twoCycle && !phase_reg) begin
               state_next = S_SETUP;
               count_next = SETUP_CNT;
               phase_next = 1'b1;
            end else begin
               state_next = S_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= S_IDLE;
         count_reg <= 8'h00;
         phase_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         phase_reg <= phase_next;
      end
   end
   // ==========================================
   // Operation latch
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         kind_reg <= OP_READ;
         code_reg <= 8'h00;
         wdata_reg <= 16'h0000;
         wordMode_reg <= CFG_RESET[CFG_WORD];
         addrPins <= 18'h00000;
         addrLow_reg <= 1'b0;
      end else if (accept) begin
         kind_reg <= opKind;
         code_reg <= opCode;
         wdata_reg <= opWdata;
         wordMode_reg <= wordCfg;
         addrPins <= startWord;
         addrLow_reg <= opAddr[0];
      end
   end
   // ==========================================
   // Strobes and data pins
   logic [15:0] oeNext;
   logic [15:0] outNext;
   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : gDq
         if (i == 15) begin : gTop
            assign oeNext[i] = wordMode_reg ? (driveNext && wideNext) : 1'b1;
            assign outNext[i] = wordMode_reg ? driveWord[i] : addrLow_reg;
         end else if (i < 8) begin : gLow
            assign oeNext[i] = driveNext;
            assign outNext[i] = driveWord[i];
         end else begin : gHigh
            assign oeNext[i] = driveNext && wideNext;
            assign outNext[i] = driveWord[i];
         end
      end
   endgenerate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chipEnableN <= 1'b1;
         outEnableN <= 1'b1;
         writeEnableN <= 1'b1;
         dqOe <= 16'h0000;
         dqOut <= 16'h0000;
      end else begin
         chipEnableN <= state_next != S_STROBE;
         outEnableN <= !(state_next == S_STROBE && isRead);
         writeEnableN <= !(state_next == S_STROBE && !isRead);
         dqOe <= oeNext;
         dqOut <= outNext;
      end
   end
   // ==========================================
   // Read capture, mode shadow and refusal flag
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 16'h0000;
         lastCode_reg <= 8'h00;
      end else if (strobeEnd) begin
         if (isRead) rdata_reg <= wordMode_reg ? syncDq : {8'h00, syncDq[7:0]};
         else lastCode_reg <= curCode;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= MODE_ARRAY;
      end else if (opEnd && twoCycle) begin
         mode_reg <= MODE_STATUS;
      end else if (opEnd && kind_reg == OP_CMD) begin
         if (code_reg == CMD_READ_ARRAY) mode_reg <= MODE_ARRAY;
         else if (code_reg == CMD_IDENT) mode_reg <= MODE_IDENT;
         else if (code_reg == CMD_READ_STATUS) mode_reg <= MODE_STATUS;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) refused_reg <= 1'b0;
      else if (refuse) refused_reg <= 1'b1;
      else if (refuseClr) refused_reg <= 1'b0;
   end
   // ==========================================
   // Supply and protection pins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_reg <= 3'h0;
         programSupplyHigh <= 1'b0;
         byteSelN <= CFG_RESET[CFG_WORD];
         resetPowerdownN <= 1'b1;
         identHighVoltage <= 1'b0;
      end else begin
         if (!holdPins) hold_reg <= {cfg[CFG_UNLOCK], cfg[CFG_WP], cfg[CFG_VPP]};
         programSupplyHigh <= hold_reg[0] || (busy && twoCycle);
         byteSelN <= holdPins ? wordMode_reg : wordCfg;
         resetPowerdownN <= !cfg[CFG_SLEEP];
         identHighVoltage <= cfg[CFG_IDENT];
      end
   end
   assign wpPin = hold_reg[1];
   assign unlockHighVoltage = hold_reg[2];
   // ==========================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence sWriteRise;
      $rose(writeEnableN);
   endsequence
   sequence sCmdDone(logic [7:0] c);
      sWriteRise ##0 (kind_reg == OP_CMD && lastCode_reg == c);
   endsequence
   property p_readStrobe;
      !outEnableN |-> writeEnableN && !chipEnableN && $stable(addrPins);
   endproperty
   a_readStrobe: assert property (p_readStrobe) else $error("read strobe shape");
   property p_cmdStrobe;
      !writeEnableN |-> outEnableN && !chipEnableN && dqOe[7:0] == 8'hff && $stable(addrPins);
   endproperty
   a_cmdStrobe: assert property (p_cmdStrobe) else $error("command strobe shape");
   property p_dataWidth;
      (!writeEnableN && dataPhase) |-> (wordMode_reg ? dqOe == 16'hffff : dqOe[14:8] == 7'h00)
         && programSupplyHigh;
   endproperty
   a_dataWidth: assert property (p_dataWidth) else $error("array write pins");
   property p_supply;
      ($fell(writeEnableN) && phase_reg) |-> programSupplyHigh [*8];
   endproperty
   a_supply: assert property (p_supply) else $error("supply dropped in write");
   property p_setupFirst;
      (sWriteRise ##0 dataPhase) |-> $past(lastCode_reg) == CMD_WRITE_SETUP;
   endproperty
   a_setupFirst: assert property (p_setupFirst) else $error("data without setup");
   property p_unlockHeld;
      (busy && $past(busy)) |-> $stable(wpPin) && $stable(unlockHighVoltage);
   endproperty
   a_unlockHeld: assert property (p_unlockHeld) else $error("unlock changed in op");
   property p_identMode;
      sCmdDone(CMD_IDENT) |-> ##[1:8] mode_reg == MODE_IDENT;
   endproperty
   a_identMode: assert property (p_identMode) else $error("ident mode missed");
   property p_arrayMode;
      sCmdDone(CMD_READ_ARRAY) |-> ##[1:8] mode_reg == MODE_ARRAY;
   endproperty
   a_arrayMode: assert property (p_arrayMode) else $error("array mode missed");
   property p_bootRefuse;
      refuse |=> refused_reg && !busy;
   endproperty
   a_bootRefuse: assert property (p_bootRefuse) else $error("boot op not refused");
endmodule
`default_nettype wire

// [testbench/flash_dev_model.sv]
// Behavioural boot-block flash device on the far side of the host controller
`default_nettype none
module flash_dev_model #(
   parameter bit BOOT_TOP = 1'b0,
   parameter logic [7:0] MAKER_ID = 8'h3c, // Arbitrary value
   parameter logic [7:0] PART_ID = 8'h5e, // Arbitrary value
   parameter logic [7:0] PART_HI = 8'h27 // Arbitrary value
) (
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic byteN,
   input wire logic [17:0] addr,
   input wire logic [15:0] dq,
   input wire logic rpN,
   input wire logic unlock,
   input wire logic wp,
   input wire logic vpp,
   input wire logic idv,
   output logic [15:0] devDq,
   output logic [15:0] devOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [int];
   logic [1:0] mode = 2'h0;
   logic [1:0] pend = 2'h0;
   logic [7:0] st = 8'h80;
   logic [7:0] stL = 8'h80;
   logic act = 1'b0;
   logic [15:0] val;
   logic [15:0] held = 16'h0;
   int bs [8];
   // ==========================================
   // Block map
   initial begin
      if (BOOT_TOP) begin
         bs = '{0, 'h10000, 'h20000, 'h30000, 'h3c000, 'h3d000, 'h3e000, 'h40000};
      end else begin
         bs = '{0, 'h2000, 'h3000, 'h4000, 'h10000, 'h20000, 'h30000, 'h40000};
      end
   end
   function automatic int blk(input int w);
      for (int i = 0; i < 7; i++) begin
         if (w >= bs[i] && w < bs[i+1]) begin
            return i;
         end
      end
      return 0;
   endfunction
   // ==========================================
   // Command and data capture
   task automatic capture();
      logic [15:0] d;
      logic ok;
      int b;
      d = dq;
      b = blk(int'(addr));
      ok = (b != (BOOT_TOP ? 6 : 0)) || unlock || wp;
      if (!vpp && pend != 2'h0) st[3] = 1'b1;
      if (pend == 2'h1 && ok && !st[3]) begin
         if (!mem.exists(addr)) mem[addr] = 16'hffff;
         if (!byteN) mem[addr] &= dq[15] ? {d[7:0], 8'hff} : {8'hff, d[7:0]};
         else mem[addr] &= d;
      end
      if (pend == 2'h2 && d[7:0] == 8'hd0 && ok && !st[3]) begin
         for (int k = bs[b]; k < bs[b+1]; k++) mem.delete(k);
      end
      if (pend != 2'h0) mode = 2'h1;
      else if (d[7:0] == 8'hff) mode = 2'h0;
      else if (d[7:0] == 8'h90) mode = 2'h2;
      else if (d[7:0] == 8'h70) mode = 2'h1;
      else if (d[7:0] == 8'h50) st = 8'h80;
      if (pend == 2'h0 && (d[7:0] == 8'h40 || d[7:0] == 8'h10)) pend = 2'h1;
      else if (pend == 2'h0 && d[7:0] == 8'h20) pend = 2'h2;
      else pend = 2'h0;
   endtask
   always @(ceN or weN) begin
      if (!ceN && !weN && oeN) begin
         act = 1'b1;
      end else if (act) begin
         act = 1'b0;
         capture();
      end
   end
   always @(rpN) begin
      if (!rpN) begin
         mode = 2'h0;
         pend = 2'h0;
         st = 8'h80;
      end
   end
   always @(negedge ceN or negedge oeN) begin
      if (!ceN && !oeN) stL = st;
   end
   // ==========================================
   // Read path
   always @(ceN, oeN, weN, byteN, addr, dq, mode, idv, stL, rpN) begin
      logic [1:0] m;
      logic drv;
      m = idv ? 2'h2 : mode;
      drv = !ceN && !oeN && weN && rpN;
      val = mem.exists(addr) ? mem[addr] : 16'hffff;
      if (m == 2'h0 && !byteN) val = {8'h00, dq[15] ? val[15:8] : val[7:0]};
      else if (m == 2'h1) val = {8'h00, stL};
      else if (m == 2'h2) val = addr[0] ? {PART_HI, PART_ID} : {8'h00, MAKER_ID};
      devOe = drv ? (byteN ? 16'hffff : 16'h00ff) : 16'h0000;
      if (drv) held = ~val;
      devDq = (val & devOe) | (held & ~devOe);
   end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench of the flash host controller against a device model
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_host_pkg::*;
   localparam logic [7:0] MAKER = 8'h3c;
   localparam logic [7:0] PART = 8'h5e;
   localparam logic [7:0] PARTHI = 8'h27;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic ceN, oeN, weN, byteN, wp, rpN, unl, vpp, idv, e;
   logic [17:0] addrPins;
   logic [15:0] dqOut, dqOe, devDq, devOe, bus;
   int numErrors = 0;
   int totalChecks = 0;
   assign bus = (dqOe & dqOut) | (~dqOe & devDq);
   flash_host flash_host_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chipEnableN(ceN), .outEnableN(oeN), .writeEnableN(weN),
      .byteSelN(byteN), .addrPins(addrPins), .dqIn(bus), .dqOut(dqOut), .dqOe(dqOe),
      .wpPin(wp), .resetPowerdownN(rpN), .unlockHighVoltage(unl), .programSupplyHigh(vpp),
      .identHighVoltage(idv));
   flash_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART), .PART_HI(PARTHI)) flash_dev_model_inst (
      .ceN(ceN), .oeN(oeN), .weN(weN), .byteN(byteN), .addr(addrPins), .dq(bus), .rpN(rpN),
      .unlock(unl), .wp(wp), .vpp(vpp), .idv(idv), .devDq(devDq), .devOe(devOe));
   // ==========================================
   // Bus tasks
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      totalChecks++;
      if (g !== x) begin
         numErrors++;
         $display("FAIL %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle();
      r = 32'h1;
      while (r[ST_BUSY] !== 1'b0) apb(1'b0, OFF_STATUS, 32'h0);
   endtask
   task automatic op(input logic [31:0] w);
      apb(1'b1, OFF_OP, w);
      idle();
   endtask
   task automatic cmd(input logic [7:0] c);
      op({16'h0, c, 6'h0, OP_CMD});
   endtask
   task automatic rd(input logic [18:0] a, input logic [15:0] x);
      apb(1'b1, OFF_ADDR, 32'(a));
      op({30'h0, OP_READ});
      apb(1'b0, OFF_RDATA, 32'h0);
      chk("rdata", {16'h0, x}, r);
   endtask
   task automatic prog(input logic [18:0] a, input logic [15:0] d);
      apb(1'b1, OFF_ADDR, 32'(a));
      apb(1'b1, OFF_WDATA, {16'h0, d});
      op({30'h0, OP_PROG});
   endtask
   task automatic endOfTest();
      $display("checks %0d errors %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========================================
   // Clock, watchdog, tests
   always @(posedge clk) begin
      if ((dqOe & devOe) != 16'h0000) begin
         numErrors++;
         $display("FAIL contention expected %h seen %h", 16'h0000, dqOe & devOe);
      end
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      numErrors++;
      endOfTest();
   end
   initial begin
      {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      chk("strobes", 32'h7, {29'h0, ceN, oeN, weN});
      apb(1'b0, OFF_CFG, 32'h0);
      chk("cfg", 32'h1, r);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("status", 32'h0, r);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      rd(19'h04000, 16'hffff);
      $display("test reset done");
      prog(19'h04000, 16'h1234);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("mode", 32'h10, r & 32'h30);
      rd(19'h04000, 16'h0080);
      cmd(8'hff);
      rd(19'h04000, 16'h1234);
      prog(19'h04000, 16'hff0f);
      cmd(8'hff);
      rd(19'h04000, 16'h1204);
      rd(19'h04000, 16'h1204);
      apb(1'b1, OFF_OP, {16'h0, 8'hff, 6'h0, OP_CMD});
      apb(1'b1, OFF_OP, {16'h0, 8'hff, 6'h0, OP_CMD});
      chk("busyop", 32'h1, {31'h0, e});
      idle();
      $display("test program done");
      prog(19'h00010, 16'h0000);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("refused", 32'h2, r & 32'h2);
      apb(1'b1, OFF_STATUS, 32'h2);
      cmd(8'hff);
      rd(19'h00010, 16'hffff);
      apb(1'b1, OFF_CFG, 32'h3);
      prog(19'h00010, 16'h00a5);
      cmd(8'hff);
      rd(19'h00010, 16'h00a5);
      apb(1'b1, OFF_CFG, 32'h5);
      prog(19'h00020, 16'h005a);
      cmd(8'hff);
      rd(19'h00020, 16'h005a);
      apb(1'b1, OFF_CFG, 32'h1);
      prog(19'h02000, 16'h0000);
      prog(19'h03000, 16'h0000);
      apb(1'b1, OFF_ADDR, 32'h00002000);
      op({30'h0, OP_ERASE});
      cmd(8'hff);
      rd(19'h02000, 16'hffff);
      rd(19'h03000, 16'h0000);
      $display("test blocks done");
      cmd(8'h90);
      rd(19'h00000, {8'h00, MAKER});
      rd(19'h12341, {PARTHI, PART});
      cmd(8'hff);
      apb(1'b1, OFF_CFG, 32'h9);
      rd(19'h00001, {PARTHI, PART});
      apb(1'b1, OFF_CFG, 32'h1);
      rd(19'h04000, 16'h1204);
      cmd(8'h70);
      rd(19'h12345, 16'h0080);
      $display("test modes done");
      apb(1'b1, OFF_CFG, 32'h0);
      cmd(8'hff);
      rd(19'h08000, 16'h0004);
      rd(19'h08001, 16'h0012);
      prog(19'h08001, 16'h0010);
      cmd(8'hff);
      rd(19'h08001, 16'h0010);
      cmd(8'h70);
      rd(19'h00000, 16'h0080);
      apb(1'b1, OFF_CFG, 32'h21);
      apb(1'b1, OFF_CFG, 32'h1);
      rd(19'h04000, 16'h1004);
      $display("test byte done");
      endOfTest();
   end
endmodule
`default_nettype wire
